/* File: ccl_comparator_ctrl.v */
// Purpose: apb register file and output logic for two comparators
// Assumes: inputs synchronous to pclk; timer clock sampled on pclk
// Notes: event flags are sticky, cleared by a read of the flag register
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "ccl_defs.vh"

module ccl_comparator_ctrl #(
	parameter TWO_CMP = 1 // 1 builds the larger, two-comparator variant
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] raw_compare,
	input wire timer_prescaled_clk,
	input wire [1:0] pin_direction_bit,
	output reg [1:0] cmp_on,
	output reg [1:0] cmp_fast_mode,
	output reg [1:0] cmp_hysteresis_on,
	output reg [3:0] plus_input_sel,
	output reg [3:0] minus_input_sel,
	output reg [1:0] timer_result,
	output reg [1:0] pin_out,
	output reg [1:0] pin_oe,
	output reg [1:0] cmp_event_flag,
	output wire irq
);

	// per comparator control registers
	reg [7:0] main_reg [0:1];
	reg [7:0] inputs_reg [0:1];
	reg [1:0] raw_q; // sampled raw compare
	reg [1:0] cmp_result; // polarity-corrected result bit
	reg [1:0] result_prev; // for edge detection
	reg [1:0] sync_hold; // latched on timer falling edge
	reg timer_clk_q; // previous timer clock sample
	reg [1:0] irq_mask;
	reg [31:0] rdata_q;
	reg [1:0] next_flag;
	integer i; // loop index, register process only
	integer j; // loop index, result and flag process only
	integer k; // loop index, output process only

	// apb decode: zero wait states
	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = rdata_q;

	// true when the address equals the given register offset
	function hit;
		input [11:0] addr;
		input [11:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// timer clock falling edge seen on pclk
	wire timer_fall = timer_clk_q & ~timer_prescaled_clk;

	// read data mux; absent registers and bits read zero
	reg [31:0] rmux;
	always @* begin
		rmux = 32'h00000000;
		// RULE2 live result shows in the read-only bit
		if (hit(paddr, `CCL_OFF_C1_MAIN))
			rmux[7:0] = {main_reg[0][7], cmp_result[0], main_reg[0][5:0]};
		else if (hit(paddr, `CCL_OFF_C1_INPUTS))
			rmux[7:0] = inputs_reg[0];
		else if (hit(paddr, `CCL_OFF_C2_MAIN) && TWO_CMP != 0)
			rmux[7:0] = {main_reg[1][7], cmp_result[1], main_reg[1][5:0]};
		else if (hit(paddr, `CCL_OFF_C2_INPUTS) && TWO_CMP != 0)
			rmux[7:0] = inputs_reg[1];
		// RULE12 mirror of results
		else if (hit(paddr, `CCL_OFF_MIRROR))
			rmux[1:0] = cmp_result;
		else if (hit(paddr, `CCL_OFF_FLAGS))
			rmux[1:0] = cmp_event_flag;
		else if (hit(paddr, `CCL_OFF_MASK))
			rmux[1:0] = irq_mask;
	end

	// registers, result path and flags
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// RULE14 reset values
			main_reg[0] <= `CCL_MAIN_RESET;
			main_reg[1] <= `CCL_MAIN_RESET;
			inputs_reg[0] <= `CCL_INPUTS_RESET;
			inputs_reg[1] <= `CCL_INPUTS_RESET;
			raw_q <= 2'h0;
			result_prev <= 2'h0;
			sync_hold <= 2'h0;
			timer_clk_q <= 1'b0;
			irq_mask <= 2'h0;
			rdata_q <= 32'h00000000;
			cmp_event_flag <= 2'h0;
		end else begin
			timer_clk_q <= timer_prescaled_clk;
			// RULE15 register raw result each cycle
			raw_q <= raw_compare;
			if (rd_en)
				rdata_q <= rmux;
			for (i = 0; i < 2; i = i + 1) begin
				// RULE19 independent copy per comparator
				if (i == 0 || TWO_CMP != 0) begin
					// RULE13 writes mask main bits 6 and 3, inputs bits 3:2, in both variants
					if (wr_en && paddr == ((i == 0) ? `CCL_OFF_C1_MAIN : `CCL_OFF_C2_MAIN))
						main_reg[i] <= pwdata[7:0] & `CCL_MAIN_WMASK;
					if (wr_en && paddr == ((i == 0) ? `CCL_OFF_C1_INPUTS : `CCL_OFF_C2_INPUTS))
						inputs_reg[i] <= pwdata[7:0] & `CCL_INPUTS_WMASK;
				end
				// RULE16 latch on prescaled timer falling edge
				if (timer_fall)
					sync_hold[i] <= cmp_result[i];
			end
			result_prev <= cmp_result;
			if (wr_en && paddr == `CCL_OFF_MASK)
				irq_mask <= pwdata[1:0];
			cmp_event_flag <= next_flag;
		end
	end

	// result, edges and flag next state
	always @* begin
		for (j = 0; j < 2; j = j + 1) begin
			// RULE2 polarity; RULE18 disabled reads low before inversion
			cmp_result[j] = (raw_q[j] & main_reg[j][`CCL_ON_BIT])
				^ main_reg[j][`CCL_INVERT_BIT];
			if (j == 1 && TWO_CMP == 0)
				cmp_result[j] = 1'b0;
		end
		next_flag = cmp_event_flag;
		// RULE17 read clears, edge sets win
		if (rd_en && paddr == `CCL_OFF_FLAGS)
			next_flag = 2'h0;
		for (j = 0; j < 2; j = j + 1) begin
			// RULE8 rising edge
			if (inputs_reg[j][`CCL_RISE_BIT] & cmp_result[j] & ~result_prev[j])
				next_flag[j] = 1'b1;
			// RULE9 falling edge
			if (inputs_reg[j][`CCL_FALL_BIT] & ~cmp_result[j] & result_prev[j])
				next_flag[j] = 1'b1;
		end
	end

	// analog core controls and delivered outputs
	always @* begin
		for (k = 0; k < 2; k = k + 1) begin
			// RULE1 power enable
			cmp_on[k] = main_reg[k][`CCL_ON_BIT];
			// RULE4 speed select
			cmp_fast_mode[k] = main_reg[k][`CCL_FAST_BIT];
			// RULE5 hysteresis
			cmp_hysteresis_on[k] = main_reg[k][`CCL_HYS_BIT];
			// RULE10 plus mux code
			plus_input_sel[2*k +: 2] = inputs_reg[k][5:4];
			// RULE11 minus mux, one bit on small variant
			minus_input_sel[2*k +: 2] = (TWO_CMP != 0) ? inputs_reg[k][1:0]
				: {1'b0, inputs_reg[k][0]};
			// RULE6 synchronised path; RULE7 direct path
			timer_result[k] = main_reg[k][`CCL_SYNC_BIT] ? sync_hold[k] : cmp_result[k];
			// RULE3 pin drive, independent of enable
			pin_out[k] = timer_result[k];
			pin_oe[k] = main_reg[k][`CCL_PIN_EN_BIT] & ~pin_direction_bit[k];
		end
	end

	// level interrupt from unmasked sticky flags
	assign irq = |(cmp_event_flag & irq_mask);

endmodule

/* File: ccl_defs.vh */
// Purpose: constants for the comparator control logic
// Assumes: apb byte addresses, one aligned word per register
// Notes: offsets have no printed value and are set here
//
// How it works
// RULE1 - enable bit powers comparator, clear disables
// RULE2 - result is plus above minus, invertible
// RULE3 - pin drive gated by direction, not enable
// RULE4 - speed bit selects fast mode, resets one
// RULE5 - hysteresis bit drives core hysteresis enable
// RULE6 - sync bit updates on timer falling edge
// RULE7 - sync clear passes result straight through
// RULE8 - rising enable lets rising edge set flag
// RULE9 - falling enable lets falling edge set flag
// RULE10 - plus select: pin, dac, fixed, ground
// RULE11 - minus select two bits, one on small
// RULE12 - mirror register holds both results
// RULE13 - unimplemented bits read as zero; minus select bit 1 still reads back on small
// RULE14 - all bits reset zero except speed bit
// RULE15 - raw result registered every clock cycle
// RULE16 - sync latch uses prescaled timer clock
// RULE17 - flag set wins over software clear
// RULE18 - polarity or enable change may set flag
// RULE19 - each comparator has own registers, logic
`ifndef CCL_DEFS_VH
`define CCL_DEFS_VH
// register byte offsets
`define CCL_OFF_C1_MAIN 12'h000
`define CCL_OFF_C1_INPUTS 12'h004
`define CCL_OFF_C2_MAIN 12'h008
`define CCL_OFF_C2_INPUTS 12'h00c
`define CCL_OFF_MIRROR 12'h010
`define CCL_OFF_FLAGS 12'h014
`define CCL_OFF_MASK 12'h018
// main control field positions
`define CCL_ON_BIT 7
`define CCL_RESULT_BIT 6
`define CCL_PIN_EN_BIT 5
`define CCL_INVERT_BIT 4
`define CCL_FAST_BIT 2
`define CCL_HYS_BIT 1
`define CCL_SYNC_BIT 0
// inputs control field positions
`define CCL_RISE_BIT 7
`define CCL_FALL_BIT 6
// writable masks and reset values
`define CCL_MAIN_WMASK 8'hb7
`define CCL_INPUTS_WMASK 8'hf3
`define CCL_MAIN_RESET 8'h04
`define CCL_INPUTS_RESET 8'h00
`endif

/* File: ccl_props.sv */
// Purpose: port checks for the comparator control
// Assumes: zero-wait apb
// Notes: control register moves are tied to write edges, flag clears to flag reads
`timescale 1ns/10ps
`include "ccl_defs.vh"
module ccl_props (
	input wire pclk, presetn, psel, penable, pwrite, irq,
	input wire [11:0] paddr,
	input wire [1:0] pin_direction_bit, pin_oe, cmp_on, cmp_fast_mode, cmp_hysteresis_on,
	input wire [1:0] cmp_event_flag,
	input wire [3:0] plus_input_sel
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite; // write access edge
	wire rdf = psel && penable && !pwrite && paddr == `CCL_OFF_FLAGS; // flag read edge
	reset_values_a: assert property (disable iff (1'b0)
		!presetn |-> cmp_fast_mode == 2'b11 && cmp_on == 2'b00 && cmp_event_flag == 2'b00)
		else $error("bad reset value");
	on_by_write_a: assert property ($changed(cmp_on) |-> $past(wr)) else $error("on moved");
	speed_by_write_a: assert property ($changed(cmp_fast_mode) |-> $past(wr)) else $error("sp");
	hys_by_write_a: assert property ($changed(cmp_hysteresis_on) |-> $past(wr)) else $error("hy");
	plus_by_write_a: assert property ($changed(plus_input_sel) |-> $past(wr)) else $error("ps");
	pin_gate_a: assert property (pin_oe[0] |-> !pin_direction_bit[0]) else $error("pin");
	flag_clear_a: assert property ($fell(cmp_event_flag[0]) |-> $past(rdf)) else $error("fl");
	irq_flag_a: assert property (irq |-> cmp_event_flag != 2'b00) else $error("irq");
endmodule
bind ccl_comparator_ctrl ccl_props u_props (.*);

/* File: ccl_core_model.sv */
// Purpose: behavioural analog core for both comparators
// Assumes: bench sets plus_above per comparator
// Notes: a powered-down core shows the inverse, not a clean level
`timescale 1ns/10ps
module ccl_core_model (
	input wire [1:0] cmp_on,
	input wire [3:0] plus_input_sel,
	input wire [1:0] plus_above,
	output wire [1:0] raw_compare
);
	genvar i;
	for (i = 0; i < 2; i = i + 1) begin : g_cmp
		assign raw_compare[i] = !cmp_on[i] ? !plus_above[i] :
			plus_input_sel[2*i+1 -: 2] != 2'b11 && plus_above[i];
	end
endmodule

/* File: comparator_control_logic_tb.sv */
// Purpose: register-level test of the comparator control
// Assumes: zero-wait apb slave
// Notes: core model drives raw_compare
`timescale 1ns/10ps
module comparator_control_logic_tb;
	reg pclk = 1'h0, presetn = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg timer_prescaled_clk = 1'h0; // timer clock idle
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rd;
	reg [1:0] pin_direction_bit = 2'h0, plus_above = 2'h3;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [1:0] raw_compare, cmp_on, cmp_fast_mode, cmp_hysteresis_on, timer_result, pin_out;
	wire [1:0] pin_oe, cmp_event_flag;
	wire [3:0] plus_input_sel, minus_input_sel;
	integer n_errors = 0, checks = 0, cyc = 0;
	always #25 pclk = ~pclk;
	ccl_comparator_ctrl u_dut (.*);
	ccl_core_model u_core (.*);
	task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp); begin
		checks = checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
		end
	end endtask
	// one apb transfer, data taken one cycle after the access edge
	task apb(input w, input [11:0] a, input [7:0] d); begin
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		rd = prdata;
	end endtask
	task rc(input [11:0] a, input [7:0] e, input [63:0] nm); begin
		apb(1'h0, a, 8'h00);
		chk(nm, rd, {24'h0, e});
	end endtask
	task report_and_stop; begin
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end endtask
	// cut a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors = n_errors + 1;
			report_and_stop;
		end
	end
	initial begin
		presetn <= 1'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rc(12'h000, 8'h04, "main1");
		rc(12'h008, 8'h04, "main2");
		rc(12'h004, 8'h00, "in1");
		rc(12'h01c, 8'h00, "unmap");
		$display("reset test done");
		apb(1'h1, 12'h000, 8'hff);
		rc(12'h000, 8'hb7, "inv");
		chk("hys", cmp_hysteresis_on, 2'h1);
		apb(1'h1, 12'h000, 8'h80);
		rc(12'h000, 8'hc0, "plain");
		rc(12'h010, 8'h01, "mirror");
		chk("fast", cmp_fast_mode, 2'h2);
		$display("control test done");
		apb(1'h1, 12'h018, 8'h01);
		apb(1'h1, 12'h004, 8'hff);
		rc(12'h004, 8'hf3, "in1");
		chk("psel", plus_input_sel, 4'h3);
		chk("irq", irq, 1'h1);
		rc(12'h014, 8'h01, "fall");
		rc(12'h014, 8'h00, "clear");
		apb(1'h1, 12'h004, 8'h80);
		rc(12'h014, 8'h01, "rise");
		apb(1'h1, 12'h004, 8'hb0);
		rc(12'h014, 8'h00, "nofall");
		apb(1'h1, 12'h004, 8'h80);
		apb(1'h1, 12'h000, 8'ha0);
		@(posedge pclk);
		chk("oe", pin_oe, 2'h1);
		chk("pin", pin_out[0], 1'h1);
		pin_direction_bit <= 2'h1;
		repeat (2) @(posedge pclk);
		chk("oe_off", pin_oe, 2'h0);
		apb(1'h1, 12'h000, 8'h00);
		rc(12'h014, 8'h01, "pend");
		apb(1'h1, 12'h000, 8'h10);
		rc(12'h014, 8'h01, "polflag");
		$display("event test done");
		report_and_stop;
	end
endmodule
